/* File: fsp_core.sv */
`timescale 1ns/10ps
module fsp_core #(
  parameter logic [31:0] REV_ID = 32'h0000_0A5A // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Instruction cache
  output logic [31:0]      imem_addr_o,
  input  wire logic [31:0] imem_data_i,
  // Data cache
  output logic             dmem_req_o,
  output logic             dmem_we_o,
  output logic [3:0]       dmem_be_o,
  output logic [31:0]      dmem_addr_o,
  output logic [31:0]      dmem_wdata_o,
  input  wire logic [31:0] dmem_rdata_i,
  // Byte-order strap and system control
  input  wire logic        big_endian_i,
  output logic             user_mode_o,
  output logic [31:0]      bus_ctrl_o,
  output logic [31:0]      cache_setup_o,
  output logic [31:0]      port_width_o
);
  logic [31:0] regs_ff [32];
  logic [31:0] pc_ff, rd_instr_ff, rd_pc_ff, ex_pc_ff, ex_a_ff, ex_b_ff, ex_imm_ff;
  logic        rd_valid_ff, rd_delay_ff, ex_valid_ff, ex_delay_ff, ex_we_ff;
  logic [5:0]  ex_op_ff, mem_op_ff;
  logic [4:0]  ex_dst_ff, ex_c0_ff, mem_dst_ff, wb_dst_ff;
  logic        mem_valid_ff, mem_we_ff, mem_big_ff, wb_we_ff;
  logic [31:0] mem_res_ff, mem_b_ff, wb_val_ff;
  logic [1:0]  mem_lo_ff;
  logic [31:0] sr_ff, cause_ff, epc_ff, badva_ff, count_ff, compare_ff;
  logic [31:0] md_hi_ff, md_lo_ff;
  logic [5:0]  md_cnt_ff;
  logic        be_s1_ff, be_s2_ff, endian_ff;
  logic [1:0]  strap_cnt_ff;

  // Byte-order strap: two flops, then taken in the cycles after reset release
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      be_s1_ff     <= 1'b0;
      be_s2_ff     <= 1'b0;
      endian_ff    <= 1'b0;
      strap_cnt_ff <= 2'h0;
    end else begin
      be_s1_ff <= big_endian_i;
      be_s2_ff <= be_s1_ff;
      if (strap_cnt_ff != fsp_pkg::STRAP_CYC) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
        endian_ff    <= be_s2_ff;
      end
    end
  end

  // Read stage decode
  logic [5:0]  rd_op;
  logic [4:0]  rd_rs, rd_rt, rd_rdi, rd_dst;
  logic [31:0] rd_imm, rd_a, rd_b, br_target;
  logic        rd_we, rd_md, rd_branch, br_taken, rd_illegal;
  assign rd_op  = rd_instr_ff[fsp_pkg::P_OP +: 6];
  assign rd_rs  = rd_instr_ff[fsp_pkg::P_RS +: 5];
  assign rd_rt  = rd_instr_ff[fsp_pkg::P_RT +: 5];
  assign rd_rdi = rd_instr_ff[fsp_pkg::P_RD +: 5];
  assign rd_imm = {{16{rd_instr_ff[15]}}, rd_instr_ff[15:0]};

  // Destination choice; JAL always names the link register
  always_comb begin
    rd_dst     = 5'h00;
    rd_illegal = 1'b0;
    unique case (rd_op)
      fsp_pkg::OP_ADD, fsp_pkg::OP_SUB, fsp_pkg::OP_AND, fsp_pkg::OP_OR, fsp_pkg::OP_SLT,
      fsp_pkg::OP_MFHI, fsp_pkg::OP_MFLO: rd_dst = rd_rdi;
      fsp_pkg::OP_ADDI, fsp_pkg::OP_LW, fsp_pkg::OP_LWL, fsp_pkg::OP_LWR,
      fsp_pkg::OP_MFC0: rd_dst = rd_rt;
      fsp_pkg::OP_JAL: rd_dst = fsp_pkg::LINK_IDX;
      fsp_pkg::OP_NOP, fsp_pkg::OP_SW, fsp_pkg::OP_BEQ, fsp_pkg::OP_BNE, fsp_pkg::OP_J,
      fsp_pkg::OP_JR, fsp_pkg::OP_MULT, fsp_pkg::OP_DIV, fsp_pkg::OP_MTHI, fsp_pkg::OP_MTLO,
      fsp_pkg::OP_MTC0, fsp_pkg::OP_RETX, fsp_pkg::OP_SYSCALL: rd_dst = 5'h00;
      default: rd_illegal = 1'b1;
    endcase
  end
  assign rd_we     = (rd_dst != 5'h00);
  assign rd_md     = rd_op inside {fsp_pkg::OP_MULT, fsp_pkg::OP_DIV, fsp_pkg::OP_MFHI,
                                   fsp_pkg::OP_MFLO, fsp_pkg::OP_MTHI, fsp_pkg::OP_MTLO};
  assign rd_branch = rd_op inside {fsp_pkg::OP_BEQ, fsp_pkg::OP_BNE, fsp_pkg::OP_J,
                                   fsp_pkg::OP_JAL, fsp_pkg::OP_JR};

  // Execute stage combinational results, needed by the bypass below
  logic [31:0] ex_addr, ex_result, c0_rdata, mem_final;
  logic        ex_load, ex_store, user_mode, exc_take, ex_go, fetch_bad, data_bad;
  logic        cpu_bad, md_stall, adv, ex_big;
  logic [4:0]  exc_code;

  // Operand read with bypass; a load still in execute is not bypassed
  function automatic logic [31:0] fsp_fwd(input logic [4:0] idx);
    if (idx == 5'h00)
      return 32'h0000_0000;
    else if (ex_valid_ff && ex_we_ff && ex_dst_ff == idx && !ex_load)
      return ex_result;
    else if (mem_valid_ff && mem_we_ff && mem_dst_ff == idx)
      return mem_final;
    else if (wb_we_ff && wb_dst_ff == idx)
      return wb_val_ff;
    else
      return regs_ff[idx];
  endfunction
  // Called procedurally so the bypass follows every stage value the function reads
  always_comb begin
    rd_a = fsp_fwd(rd_rs);
    rd_b = fsp_fwd(rd_rt);
  end

  // Branch resolution in the read stage leaves exactly one delay slot
  always_comb begin
    br_target = rd_pc_ff + 32'h4 + {rd_imm[29:0], 2'b00};
    if (rd_op == fsp_pkg::OP_J || rd_op == fsp_pkg::OP_JAL)
      br_target = {rd_pc_ff[31:28], rd_instr_ff[25:0], 2'b00};
    else if (rd_op == fsp_pkg::OP_JR)
      br_target = rd_a;
  end
  assign br_taken = rd_valid_ff && ((rd_op == fsp_pkg::OP_BEQ && rd_a == rd_b) ||
                    (rd_op == fsp_pkg::OP_BNE && rd_a != rd_b) ||
                    rd_op inside {fsp_pkg::OP_J, fsp_pkg::OP_JAL, fsp_pkg::OP_JR});

  // Interlock only result-register users; others flow past a busy unit
  assign md_stall = rd_valid_ff && rd_md && ((md_cnt_ff != 6'h00) || (ex_valid_ff &&
                    (ex_op_ff == fsp_pkg::OP_MULT || ex_op_ff == fsp_pkg::OP_DIV)));
  assign adv = !md_stall;

  // Execute: operation, coprocessor reads and exception detection
  assign user_mode = sr_ff[fsp_pkg::SR_CUR_USER];
  assign ex_addr   = ex_a_ff + ex_imm_ff;
  assign ex_load   = ex_op_ff inside {fsp_pkg::OP_LW, fsp_pkg::OP_LWL, fsp_pkg::OP_LWR};
  assign ex_store  = (ex_op_ff == fsp_pkg::OP_SW);
  assign ex_big    = endian_ff ^ (user_mode & sr_ff[fsp_pkg::SR_RE]);
  always_comb begin
    unique case (ex_c0_ff)
      fsp_pkg::C0_BUS_INTERFACE_TIMING_CONTROL: c0_rdata = bus_ctrl_o;
      fsp_pkg::C0_CONFIG:  c0_rdata = cache_setup_o;
      fsp_pkg::C0_BADVA:   c0_rdata = badva_ff;
      fsp_pkg::C0_COUNT:   c0_rdata = count_ff;
      fsp_pkg::C0_PORTW:   c0_rdata = port_width_o;
      fsp_pkg::C0_COMPARE: c0_rdata = compare_ff;
      fsp_pkg::C0_STATE:   c0_rdata = sr_ff;
      fsp_pkg::C0_CAUSE:   c0_rdata = cause_ff;
      fsp_pkg::C0_EPC:     c0_rdata = epc_ff;
      fsp_pkg::C0_REVISION_IDENTIFIER:    c0_rdata = REV_ID;
      default:             c0_rdata = 32'h0000_0000;
    endcase
  end
  always_comb begin
    unique case (ex_op_ff)
      fsp_pkg::OP_ADD:  ex_result = ex_a_ff + ex_b_ff;
      fsp_pkg::OP_SUB:  ex_result = ex_a_ff - ex_b_ff;
      fsp_pkg::OP_AND:  ex_result = ex_a_ff & ex_b_ff;
      fsp_pkg::OP_OR:   ex_result = ex_a_ff | ex_b_ff;
      fsp_pkg::OP_SLT:  ex_result = {31'h0, $signed(ex_a_ff) < $signed(ex_b_ff)};
      fsp_pkg::OP_ADDI: ex_result = ex_addr;
      fsp_pkg::OP_JAL:  ex_result = ex_pc_ff + 32'h8;
      fsp_pkg::OP_MFHI: ex_result = md_hi_ff;
      fsp_pkg::OP_MFLO: ex_result = md_lo_ff;
      fsp_pkg::OP_MFC0: ex_result = c0_rdata;
      default:          ex_result = ex_addr;
    endcase
  end
  assign fetch_bad = user_mode && ex_pc_ff[31];
  assign data_bad  = ((ex_load || ex_store) && user_mode && ex_addr[31]) ||
                     ((ex_op_ff == fsp_pkg::OP_LW || ex_store) && ex_addr[1:0] != 2'b00);
  assign cpu_bad   = ex_op_ff inside {fsp_pkg::OP_MFC0, fsp_pkg::OP_MTC0, fsp_pkg::OP_RETX} &&
                     user_mode && !sr_ff[fsp_pkg::SR_CU0];
  logic ex_illegal_ff;
  always_comb begin
    exc_code = fsp_pkg::EXC_ADEL;
    if (fetch_bad)
      exc_code = fsp_pkg::EXC_ADEL;
    else if (ex_illegal_ff)
      exc_code = fsp_pkg::EXC_RI;
    else if (cpu_bad)
      exc_code = fsp_pkg::EXC_CPU;
    else if (ex_op_ff == fsp_pkg::OP_SYSCALL)
      exc_code = fsp_pkg::EXC_SYS;
    else if (ex_store)
      exc_code = fsp_pkg::EXC_ADES;
  end
  assign exc_take = ex_valid_ff && (fetch_bad || ex_illegal_ff || cpu_bad || data_bad ||
                    ex_op_ff == fsp_pkg::OP_SYSCALL);
  assign ex_go = ex_valid_ff && !exc_take;

  // Pipeline registers; an exception in execute flushes it and everything younger
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_ff <= fsp_pkg::RST_VEC;
      {rd_valid_ff, rd_delay_ff, ex_valid_ff, ex_delay_ff, ex_we_ff} <= 5'h00;
      {rd_instr_ff, rd_pc_ff, ex_pc_ff, ex_a_ff, ex_b_ff, ex_imm_ff} <= {6{32'h0}};
      {ex_op_ff, ex_dst_ff, ex_c0_ff, ex_illegal_ff} <= 17'h00000;
    end else if (exc_take) begin
      pc_ff       <= fsp_pkg::EXC_VEC;
      rd_valid_ff <= 1'b0;
      ex_valid_ff <= 1'b0;
    end else if (adv) begin
      pc_ff         <= br_taken ? br_target : pc_ff + 32'h4;
      rd_valid_ff   <= 1'b1;
      rd_instr_ff   <= imem_data_i;
      rd_pc_ff      <= pc_ff;
      rd_delay_ff   <= rd_valid_ff && rd_branch;
      ex_valid_ff   <= rd_valid_ff;
      ex_op_ff      <= rd_op;
      ex_pc_ff      <= rd_pc_ff;
      ex_a_ff       <= rd_a;
      ex_b_ff       <= rd_b;
      ex_imm_ff     <= rd_imm;
      ex_dst_ff     <= rd_dst;
      ex_we_ff      <= rd_we;
      ex_c0_ff      <= rd_rdi;
      ex_delay_ff   <= rd_delay_ff;
      ex_illegal_ff <= rd_illegal;
    end else begin
      ex_valid_ff <= 1'b0; // Bubble while the read stage waits
    end
  end

  // Memory stage and data cache request; only loads and stores reach the cache
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {mem_valid_ff, mem_we_ff, mem_big_ff, dmem_req_o, dmem_we_o} <= 5'h00;
      {mem_op_ff, mem_dst_ff, mem_lo_ff} <= 13'h0000;
      {mem_res_ff, mem_b_ff, dmem_addr_o, dmem_wdata_o} <= {4{32'h0}};
      dmem_be_o <= 4'h0;
    end else begin
      mem_valid_ff <= ex_go;
      mem_op_ff    <= ex_op_ff;
      mem_we_ff    <= ex_we_ff;
      mem_dst_ff   <= ex_dst_ff;
      mem_res_ff   <= ex_result;
      mem_b_ff     <= ex_b_ff;
      mem_lo_ff    <= ex_addr[1:0];
      mem_big_ff   <= ex_big;
      dmem_req_o   <= ex_go && (ex_load || ex_store);
      dmem_we_o    <= ex_go && ex_store;
      dmem_be_o    <= (ex_go && (ex_load || ex_store)) ? 4'hF : 4'h0;
      dmem_addr_o  <= {ex_addr[31:2], 2'b00};
      dmem_wdata_o <= ex_b_ff;
    end
  end

  // Load merge; the base comes from the writeback value just ahead when it names the same register
  logic [31:0] merge_base;
  logic [4:0]  shl_amt, shr_amt;
  assign merge_base = (wb_we_ff && wb_dst_ff == mem_dst_ff) ? wb_val_ff : mem_b_ff;
  assign shl_amt = {(mem_big_ff ? mem_lo_ff : 2'h3 - mem_lo_ff), 3'b000};
  assign shr_amt = {(mem_big_ff ? 2'h3 - mem_lo_ff : mem_lo_ff), 3'b000};
  always_comb begin
    unique case (mem_op_ff)
      fsp_pkg::OP_LW:  mem_final = dmem_rdata_i;
      fsp_pkg::OP_LWL: mem_final = (dmem_rdata_i << shl_amt) |
                                   (merge_base & ~(32'hFFFF_FFFF << shl_amt));
      fsp_pkg::OP_LWR: mem_final = (dmem_rdata_i >> shr_amt) |
                                   (merge_base & ~(32'hFFFF_FFFF >> shr_amt));
      default:         mem_final = mem_res_ff;
    endcase
  end

  // Writeback stage and register file; index zero never stored
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_we_ff  <= 1'b0;
      wb_dst_ff <= 5'h00;
      wb_val_ff <= fsp_pkg::ZERO_RST;
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= fsp_pkg::ZERO_RST;
      end
    end else begin
      wb_we_ff  <= mem_valid_ff && mem_we_ff;
      wb_dst_ff <= mem_dst_ff;
      wb_val_ff <= mem_final;
      if (wb_we_ff && wb_dst_ff != 5'h00) begin
        regs_ff[wb_dst_ff] <= wb_val_ff;
      end
    end
  end

  // Multiply/divide: results land at once, reads wait out the latency count
  logic [63:0] md_prod;
  assign md_prod = $signed(ex_a_ff) * $signed(ex_b_ff);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      md_hi_ff  <= fsp_pkg::ZERO_RST;
      md_lo_ff  <= fsp_pkg::ZERO_RST;
      md_cnt_ff <= 6'h00;
    end else begin
      if (md_cnt_ff != 6'h00)
        md_cnt_ff <= md_cnt_ff - 6'h01;
      if (ex_go && ex_op_ff == fsp_pkg::OP_MULT) begin
        md_hi_ff  <= md_prod[63:32];
        md_lo_ff  <= md_prod[31:0];
        md_cnt_ff <= fsp_pkg::MUL_CYC;
      end else if (ex_go && ex_op_ff == fsp_pkg::OP_DIV) begin
        md_hi_ff  <= (ex_b_ff == 32'h0) ? ex_a_ff : 32'($signed(ex_a_ff) % $signed(ex_b_ff));
        md_lo_ff  <= (ex_b_ff == 32'h0) ? 32'hFFFF_FFFF :
                     32'($signed(ex_a_ff) / $signed(ex_b_ff));
        md_cnt_ff <= fsp_pkg::DIV_CYC;
      end else if (ex_go && ex_op_ff == fsp_pkg::OP_MTHI) begin
        md_hi_ff <= ex_a_ff;
      end else if (ex_go && ex_op_ff == fsp_pkg::OP_MTLO) begin
        md_lo_ff <= ex_a_ff;
      end
    end
  end

  // Mode stack: exception pushes kernel, return pops; explicit writes otherwise
  logic c0_wr;
  assign c0_wr = ex_go && ex_op_ff == fsp_pkg::OP_MTC0;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sr_ff <= fsp_pkg::SR_RST;
    end else if (exc_take) begin
      sr_ff[fsp_pkg::SR_OLD_USER]  <= sr_ff[fsp_pkg::SR_PREV_USER];
      sr_ff[fsp_pkg::SR_PREV_USER] <= sr_ff[fsp_pkg::SR_CUR_USER];
      sr_ff[fsp_pkg::SR_CUR_USER]  <= 1'b0;
    end else if (ex_go && ex_op_ff == fsp_pkg::OP_RETX) begin
      sr_ff[fsp_pkg::SR_CUR_USER]  <= sr_ff[fsp_pkg::SR_PREV_USER];
      sr_ff[fsp_pkg::SR_PREV_USER] <= sr_ff[fsp_pkg::SR_OLD_USER];
    end else if (c0_wr && ex_c0_ff == fsp_pkg::C0_STATE) begin
      sr_ff <= ex_b_ff;
    end
  end

  // Exception capture; the timer bit is sticky and its set beats a clearing write
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {cause_ff, epc_ff, badva_ff} <= {3{fsp_pkg::ZERO_RST}};
    end else begin
      if (exc_take) begin
        cause_ff[fsp_pkg::CAUSE_CODE +: 5] <= exc_code;
        cause_ff[fsp_pkg::CAUSE_BD]        <= ex_delay_ff;
        epc_ff <= ex_delay_ff ? ex_pc_ff - 32'h4 : ex_pc_ff;
        if (fetch_bad)
          badva_ff <= ex_pc_ff;
        else if (data_bad)
          badva_ff <= ex_addr;
      end else if (c0_wr && ex_c0_ff == fsp_pkg::C0_CAUSE) begin
        cause_ff <= (cause_ff & ~fsp_pkg::CAUSE_WMASK) | (ex_b_ff & fsp_pkg::CAUSE_WMASK);
      end
      if (count_ff == compare_ff)
        cause_ff[fsp_pkg::CAUSE_TIMER] <= 1'b1;
      else if (c0_wr && ex_c0_ff == fsp_pkg::C0_COMPARE)
        cause_ff[fsp_pkg::CAUSE_TIMER] <= 1'b0;
    end
  end

  // Writable coprocessor registers; outputs may lag the write, software allows for it
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {count_ff, compare_ff, bus_ctrl_o, cache_setup_o, port_width_o} <= {5{32'h0}};
      user_mode_o <= 1'b0;
    end else begin
      count_ff    <= (c0_wr && ex_c0_ff == fsp_pkg::C0_COUNT) ? ex_b_ff : count_ff + 32'h1;
      user_mode_o <= sr_ff[fsp_pkg::SR_CUR_USER];
      if (c0_wr && ex_c0_ff == fsp_pkg::C0_COMPARE)
        compare_ff <= ex_b_ff;
      if (c0_wr && ex_c0_ff == fsp_pkg::C0_BUS_INTERFACE_TIMING_CONTROL)
        bus_ctrl_o <= ex_b_ff;
      if (c0_wr && ex_c0_ff == fsp_pkg::C0_CONFIG)
        cache_setup_o <= ex_b_ff;
      if (c0_wr && ex_c0_ff == fsp_pkg::C0_PORTW)
        port_width_o <= ex_b_ff;
    end
  end
  assign imem_addr_o = pc_ff;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_zero_reg_held:  assert property (regs_ff[0] == 32'h0)
    else $error("register zero changed");
  a_link_written:   assert property (ex_go && ex_op_ff == fsp_pkg::OP_JAL |->
    ##2 wb_we_ff && wb_dst_ff == fsp_pkg::LINK_IDX && wb_val_ff == $past(ex_pc_ff, 2) + 32'h8)
    else $error("link address not written");
  a_exc_kernel:     assert property (exc_take |=> !sr_ff[fsp_pkg::SR_CUR_USER])
    else $error("exception left user mode set");
  a_return_mode:    assert property (ex_go && ex_op_ff == fsp_pkg::OP_RETX |=>
    sr_ff[fsp_pkg::SR_CUR_USER] == $past(sr_ff[fsp_pkg::SR_PREV_USER]))
    else $error("return did not restore mode");
  a_user_segment:   assert property (ex_valid_ff && (ex_load || ex_store) && user_mode &&
    ex_addr[31] |=> !dmem_req_o) else $error("user reached kernel segment");
  a_cop_locked:     assert property (ex_valid_ff && ex_op_ff == fsp_pkg::OP_MTC0 && user_mode &&
    !sr_ff[fsp_pkg::SR_CU0] |=> !mem_valid_ff && pc_ff == fsp_pkg::EXC_VEC)
    else $error("locked coprocessor written");
  a_md_interlock:   assert property (rd_valid_ff && rd_md && md_cnt_ff != 6'h00 |=>
    !ex_valid_ff) else $error("result register read while busy");
  a_issue_rate:     assert property (rd_valid_ff && !md_stall && !exc_take |=>
    ex_valid_ff && rd_valid_ff) else $error("pipeline did not advance");
  a_bypass_next:    assert property (rd_valid_ff && adv && !exc_take && ex_valid_ff && ex_we_ff
    && !ex_load && ex_dst_ff == rd_rs && rd_rs != 5'h00 |=> ex_a_ff == $past(ex_result))
    else $error("bypass missed");
  a_delay_slot:     assert property (br_taken && adv && !exc_take |=>
    rd_valid_ff && rd_delay_ff ##1 ex_valid_ff) else $error("delay slot dropped");
  a_precise_flush:  assert property (exc_take |=> !ex_valid_ff && !rd_valid_ff &&
    !mem_valid_ff ##1 !wb_we_ff) else $error("younger instruction survived exception");
  c_exception:      cover property (exc_take ##1 pc_ff == fsp_pkg::EXC_VEC);
  c_md_stall:       cover property (md_stall [*3] ##1 !md_stall);
  c_load_merge:     cover property (mem_valid_ff && mem_op_ff == fsp_pkg::OP_LWL &&
    wb_we_ff && wb_dst_ff == mem_dst_ff);
  c_jal_taken:      cover property (br_taken && rd_op == fsp_pkg::OP_JAL);
endmodule

/* File: fsp_pkg.sv */
package fsp_pkg;
  // Instruction word fields
  localparam int P_OP = 26;
  localparam int P_RS = 21;
  localparam int P_RT = 16;
  localparam int P_RD = 11;
  localparam int P_TGT = 0;
  // Operation codes in the op field
  localparam logic [5:0] OP_NOP     = 6'h00;
  localparam logic [5:0] OP_ADD     = 6'h01;
  localparam logic [5:0] OP_SUB     = 6'h02;
  localparam logic [5:0] OP_AND     = 6'h03;
  localparam logic [5:0] OP_OR      = 6'h04;
  localparam logic [5:0] OP_SLT     = 6'h05;
  localparam logic [5:0] OP_ADDI    = 6'h06;
  localparam logic [5:0] OP_LW      = 6'h07;
  localparam logic [5:0] OP_SW      = 6'h08;
  localparam logic [5:0] OP_LWL     = 6'h09;
  localparam logic [5:0] OP_LWR     = 6'h0A;
  localparam logic [5:0] OP_BEQ     = 6'h0B;
  localparam logic [5:0] OP_BNE     = 6'h0C;
  localparam logic [5:0] OP_J       = 6'h0D;
  localparam logic [5:0] OP_JAL     = 6'h0E;
  localparam logic [5:0] OP_JR      = 6'h0F;
  localparam logic [5:0] OP_MULT    = 6'h10;
  localparam logic [5:0] OP_DIV     = 6'h11;
  localparam logic [5:0] OP_MFHI    = 6'h12;
  localparam logic [5:0] OP_MFLO    = 6'h13;
  localparam logic [5:0] OP_MTHI    = 6'h14;
  localparam logic [5:0] OP_MTLO    = 6'h15;
  localparam logic [5:0] OP_MFC0    = 6'h16;
  localparam logic [5:0] OP_MTC0    = 6'h17;
  localparam logic [5:0] OP_RETX    = 6'h18;
  localparam logic [5:0] OP_SYSCALL = 6'h19;
  // Register file
  localparam logic [4:0] LINK_IDX = 5'h1F;
  // System coprocessor register numbers
  localparam logic [4:0] C0_BUS_INTERFACE_TIMING_CONTROL = 5'h02;
  localparam logic [4:0] C0_CONFIG  = 5'h03;
  localparam logic [4:0] C0_BADVA   = 5'h08;
  localparam logic [4:0] C0_COUNT   = 5'h09;
  localparam logic [4:0] C0_PORTW   = 5'h0A;
  localparam logic [4:0] C0_COMPARE = 5'h0B;
  localparam logic [4:0] C0_STATE   = 5'h0C;
  localparam logic [4:0] C0_CAUSE   = 5'h0D;
  localparam logic [4:0] C0_EPC     = 5'h0E;
  localparam logic [4:0] C0_REVISION_IDENTIFIER    = 5'h0F;
  // State and cause fields
  localparam int SR_CUR_USER  = 1;
  localparam int SR_PREV_USER = 3;
  localparam int SR_OLD_USER  = 5;
  localparam int SR_RE        = 25;
  localparam int SR_CU0       = 28;
  localparam int CAUSE_CODE   = 2;
  localparam int CAUSE_TIMER  = 15;
  localparam int CAUSE_BD     = 31;
  localparam logic [31:0] CAUSE_WMASK = 32'h0000_0300;
  // Exception codes
  localparam logic [4:0] EXC_ADEL = 5'h04;
  localparam logic [4:0] EXC_ADES = 5'h05;
  localparam logic [4:0] EXC_SYS  = 5'h08;
  localparam logic [4:0] EXC_RI   = 5'h0A;
  localparam logic [4:0] EXC_CPU  = 5'h0B;
  // Reset values and vectors
  localparam logic [31:0] RST_VEC  = 32'hBFC0_0000;
  localparam logic [31:0] EXC_VEC  = 32'h8000_0080;
  localparam logic [31:0] SR_RST   = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // Multiply/divide latency in cycles
  localparam logic [5:0] MUL_CYC = 6'h0C;
  localparam logic [5:0] DIV_CYC = 6'h23;
  // Cycles after reset release during which the byte-order strap is taken
  localparam logic [1:0] STRAP_CYC = 2'h3;
endpackage

/* File: fsp_mem_model.sv */
`timescale 1ns/10ps
// Cache stand-in: answers in the same cycle and never stalls
module fsp_mem_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Instruction side
  input  wire logic [31:0] imem_addr_i,
  output logic [31:0]      imem_data_o,
  // Data side
  input  wire logic        dmem_req_i,
  input  wire logic        dmem_we_i,
  input  wire logic [31:0] dmem_addr_i,
  input  wire logic [31:0] dmem_wdata_i,
  output logic [31:0]      dmem_rdata_o
);
  logic [31:0] imem [64];
  logic [31:0] dmem [64];
  logic [31:0] last_ff;
  // Fetch word returned combinationally at the program counter
  assign imem_data_o = imem[imem_addr_i[7:2]];
  // Idle read lines show inverted data so a stale word never looks valid
  assign dmem_rdata_o = dmem_req_i ? dmem[dmem_addr_i[7:2]] : ~last_ff;
  // Stores land at the edge closing the memory stage
  always @(posedge clk_sys_i) begin
    if (dmem_req_i) begin
      last_ff <= dmem[dmem_addr_i[7:2]];
      if (dmem_we_i) begin
        dmem[dmem_addr_i[7:2]] <= dmem_wdata_i;
      end
    end
  end
endmodule

/* File: test_five_stage_integer_pipeline.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_five_stage_integer_pipeline;
  logic        clk_sys_i    = 1'b0;
  logic        rstn_i       = 1'b0;
  logic        big_endian_i = 1'b0;
  logic [31:0] ia, id, da, dw, dr;
  logic        dq, dwe, um;
  logic [3:0]  be;
  logic [31:0] bc, cs, pw;
  int          errors       = 0;
  int          checked      = 0;
  int          cyc          = 0;
  logic [63:0] stq[$];
  logic [63:0] rows[9];
  logic [31:0] prog[21];
  logic [31:0] hnd[11];
  function automatic logic [31:0] ins(logic [5:0] op, logic [4:0] s, logic [4:0] t,
                                      logic [15:0] im);
    return {op, s, t, im};
  endfunction
  fsp_core i_fsp_core (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .imem_addr_o(ia),
    .imem_data_i(id), .dmem_req_o(dq), .dmem_we_o(dwe), .dmem_be_o(be), .dmem_addr_o(da),
    .dmem_wdata_o(dw), .dmem_rdata_i(dr), .big_endian_i(big_endian_i), .user_mode_o(um),
    .bus_ctrl_o(bc), .cache_setup_o(cs), .port_width_o(pw));
  fsp_mem_model i_fsp_mem_model (.clk_sys_i(clk_sys_i), .imem_addr_i(ia), .imem_data_o(id),
    .dmem_req_i(dq), .dmem_we_i(dwe), .dmem_addr_i(da), .dmem_wdata_i(dw), .dmem_rdata_o(dr));
  always #20 clk_sys_i = ~clk_sys_i;
  // Record every store; aborted or dropped stores show up as extra or wrong rows
  always @(negedge clk_sys_i) begin
    cyc++;
    if (rstn_i && dq && dwe) stq.push_back({da, dw});
    `CHK(be, {4{dq}})
    if (cyc == 2000) begin errors++; close_out(); end
  end
  task automatic close_out();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    prog = '{ins(6'h06, 0, 1, 5), ins(6'h06, 1, 2, 3), ins(6'h08, 0, 2, 0), ins(6'h06, 0, 0, 7),
      ins(6'h08, 0, 0, 4), {6'h0E, 26'h3F00009}, ins(6'h06, 0, 3, 1), ins(6'h06, 0, 3, 2), 0,
      ins(6'h08, 0, 31, 8), ins(6'h08, 0, 3, 12), ins(6'h07, 0, 4, 0), 0, ins(6'h08, 0, 4, 16),
      ins(6'h10, 1, 2, 0), ins(6'h13, 0, 0, 16'h3000), ins(6'h08, 0, 6, 20),
      ins(6'h06, 0, 31, 9), ins(6'h08, 0, 31, 24), ins(6'h19, 0, 0, 0), ins(6'h08, 0, 1, 28)};
    // Handler: save return pc, load and merge into one register, set system regs, spin
    hnd = '{ins(6'h16, 0, 7, 16'h7000), ins(6'h08, 0, 7, 28), ins(6'h07, 0, 8, 0),
      ins(6'h09, 0, 8, 1), 0, ins(6'h08, 0, 8, 32), ins(6'h17, 0, 1, 16'h1000),
      ins(6'h17, 0, 2, 16'h1800), ins(6'h17, 0, 6, 16'h5000), ins(6'h0B, 0, 0, 16'hFFFF), 0};
    rows = '{{32'h0, 32'h8}, {32'h4, 32'h0}, {32'h8, 32'hBFC0001C}, {32'hC, 32'h1},
      {32'h10, 32'h8}, {32'h14, 32'h28}, {32'h18, 32'h9}, {32'h1C, 32'hBFC0004C},
      {32'h20, 32'h00080008}};
    for (int k = 0; k < 64; k++) begin
      i_fsp_mem_model.imem[k] = (k < 21) ? prog[k] : (k >= 32 && k < 43) ? hnd[k-32] : 32'h0;
      i_fsp_mem_model.dmem[k] = 32'h0;
    end
    i_fsp_mem_model.last_ff = 32'h0;
    repeat (10) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (300) @(negedge clk_sys_i);
    `CHK(stq.size(), 9)
    for (int k = 0; k < 9; k++) `CHK(stq[k], rows[k])
    `CHK(um, 1'b0)
    `CHK(bc, 32'h5)
    `CHK(cs, 32'h8)
    `CHK(pw, 32'h28)
    $display("program run done");
    rstn_i = 1'b0;
    @(negedge clk_sys_i);
    `CHK(ia, fsp_pkg::RST_VEC)
    `CHK(dq, 1'b0)
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    `CHK(ia, fsp_pkg::RST_VEC + 32'h4)
    $display("mid-run reset done");
    close_out();
  end
endmodule
